// file: src/bai_core.sv
// Byte add instruction executor with APB register access and banked data memory
//
// Added by the designer: the APB interface to the registers and the placing of the registers.
`include "bai_map.svh"
`default_nettype none
module bai_core import bai_pkg::*; (
	// APB
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Indexed pointer base
	input wire logic [11:0] index_base
);
	logic [7:0] mem_r [0:4095];
	logic [7:0] acc_r;
	logic [3:0] bank_select_register_r;
	logic xinst_r;
	logic [15:0] instr_r;
	logic busy_r;
	logic illegal_r;
	bai_phase_t phase_r;
	bai_flags_t flags_r;
	bai_dec_t dec_r;
	logic [11:0] faddr_r;
	logic [7:0] opnd_r;
	logic [8:0] sum_r;
	logic [4:0] low_r;
	logic [11:0] sw_addr_r;
	logic [11:0] base_s1_r;
	logic [11:0] base_s2_r;
	bai_dec_t dec_nxt;
	logic [11:0] faddr_nxt;
	logic wr_ok;
	logic rd_ok;
	logic start;
	logic wr_mem;
	logic [7:0] res;
	bai_flags_t flags_nxt;

	// ----------------------------------------
	// Bus decode
	// ----------------------------------------
	assign wr_ok = psel && penable && pwrite && pready;
	assign rd_ok = psel && !penable && !pwrite;
	assign start = wr_ok && paddr == `BAI_OFF_INSTR && !pslverr;

	// ----------------------------------------
	// Decode and operand address
	// ----------------------------------------
	always_comb begin
		dec_nxt.is_lit = pwdata[15:8] == `BAI_OP_LIT;
		dec_nxt.is_file = pwdata[15:10] == `BAI_OP_FILE;
		dec_nxt.dest_file = pwdata[9];
		dec_nxt.bank_sel = pwdata[8];
		dec_nxt.operand = pwdata[7:0];
		if (pwdata[8]) begin
			faddr_nxt = {bank_select_register_r, pwdata[7:0]};
		end else if (xinst_r && pwdata[7:0] <= `BAI_IDX_LIMIT) begin
			faddr_nxt = 12'(base_s2_r + {4'h0, pwdata[7:0]});
		end else if (pwdata[7:0] < `BAI_ACCESS_SPLIT) begin
			faddr_nxt = {4'h0, pwdata[7:0]};
		end else begin
			faddr_nxt = {`BAI_ACCESS_SFR_BANK, pwdata[7:0]};
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			base_s1_r <= 12'h000;
			base_s2_r <= 12'h000;
		end else begin
			base_s1_r <= index_base;
			base_s2_r <= base_s1_r;
		end
	end

	// ----------------------------------------
	// Instruction cycle sequencer
	// ----------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			phase_r <= BAI_Q1;
			busy_r <= 1'b0;
			illegal_r <= 1'b0;
			instr_r <= 16'h0000;
			dec_r <= '0;
			faddr_r <= 12'h000;
			opnd_r <= 8'h00;
			sum_r <= 9'h000;
			low_r <= 5'h00;
		end else if (start) begin
			busy_r <= dec_nxt.is_lit || dec_nxt.is_file;
			illegal_r <= !(dec_nxt.is_lit || dec_nxt.is_file);
			instr_r <= pwdata[15:0];
			dec_r <= dec_nxt;
			faddr_r <= faddr_nxt;
			phase_r <= BAI_Q1;
		end else if (busy_r) begin
			unique case (phase_r)
				BAI_Q1: begin
					phase_r <= BAI_Q2;
				end
				BAI_Q2: begin
					opnd_r <= dec_r.is_file ? mem_r[faddr_r] : dec_r.operand;
					phase_r <= BAI_Q3;
				end
				BAI_Q3: begin
					sum_r <= {1'b0, acc_r} + {1'b0, opnd_r};
					low_r <= {1'b0, acc_r[3:0]} + {1'b0, opnd_r[3:0]};
					phase_r <= BAI_Q4;
				end
				BAI_Q4: begin
					busy_r <= 1'b0;
					phase_r <= BAI_Q1;
				end
			endcase
		end
	end

	// ----------------------------------------
	// Write to destination and flags
	// ----------------------------------------
	assign res = sum_r[7:0];
	assign wr_mem = busy_r && phase_r == BAI_Q4 && dec_r.is_file && dec_r.dest_file;
	always_comb begin
		flags_nxt.c = sum_r[8];
		flags_nxt.dc = low_r[4];
		flags_nxt.z = res == 8'h00;
		flags_nxt.n = res[7];
		flags_nxt.ov = (acc_r[7] == opnd_r[7]) && (res[7] != acc_r[7]);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			acc_r <= `BAI_ACC_RST;
			flags_r <= '0;
		end else if (busy_r && phase_r == BAI_Q4) begin
			flags_r <= flags_nxt;
			if (dec_r.is_lit || !dec_r.dest_file) begin
				acc_r <= res;
			end
		end else if (wr_ok && paddr == `BAI_OFF_ACC) begin
			acc_r <= pwdata[7:0];
		end
	end

	always_ff @(posedge pclk) begin
		if (wr_mem) begin
			mem_r[faddr_r] <= res;
		end else if (wr_ok && paddr == `BAI_OFF_FDATA) begin
			mem_r[sw_addr_r] <= pwdata[7:0];
		end
	end

	// ----------------------------------------
	// Software registers
	// ----------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			xinst_r <= 1'b0;
			bank_select_register_r <= `BAI_BANK_RST;
			sw_addr_r <= 12'h000;
		end else if (wr_ok) begin
			if (paddr == `BAI_OFF_CTRL) begin
				xinst_r <= pwdata[`BAI_CTRL_XINST];
			end
			if (paddr == `BAI_OFF_BANK) begin
				bank_select_register_r <= pwdata[3:0];
			end
			if (paddr == `BAI_OFF_FADDR) begin
				sw_addr_r <= pwdata[11:0];
			end
		end
	end

	// ----------------------------------------
	// APB answer, one wait state
	// ----------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
		end else begin
			pready <= psel && penable && !pready;
			pslverr <= psel && penable && !pready &&
				(paddr > `BAI_OFF_FDATA || paddr[1:0] != 2'b00 ||
				(pwrite && paddr == `BAI_OFF_INSTR && busy_r));
			if (rd_ok) begin
				unique case (paddr)
					`BAI_OFF_CTRL: prdata <= {31'h0, xinst_r};
					`BAI_OFF_INSTR: prdata <= {16'h0, instr_r};
					`BAI_OFF_ACC: prdata <= {24'h0, acc_r};
					`BAI_OFF_BANK: prdata <= {28'h0, bank_select_register_r};
					`BAI_OFF_STATUS: prdata <= {22'h0, illegal_r, busy_r, 3'h0, flags_r};
					`BAI_OFF_FADDR: prdata <= {20'h0, sw_addr_r};
					`BAI_OFF_FDATA: prdata <= {24'h0, mem_r[sw_addr_r]};
					default: prdata <= 32'h0000_0000;
				endcase
			end
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	a_lit_sum: assert property (@(posedge pclk) disable iff (!presetn)
		start && dec_nxt.is_lit |-> ##5 acc_r == 8'($past(acc_r, 5) + $past(pwdata[7:0], 5)))
		else $error("literal add result wrong");
	a_dest_acc: assert property (@(posedge pclk) disable iff (!presetn)
		busy_r && phase_r == BAI_Q4 && dec_r.is_file && !dec_r.dest_file |=> acc_r == $past(res))
		else $error("accumulator destination not written");
	a_dest_keep: assert property (@(posedge pclk) disable iff (!presetn)
		busy_r && phase_r == BAI_Q4 && dec_r.is_file && dec_r.dest_file |=> $stable(acc_r))
		else $error("accumulator changed on file destination");
	a_bank_addr: assert property (@(posedge pclk) disable iff (!presetn)
		start && pwdata[8] |=> faddr_r == {$past(bank_select_register_r), $past(pwdata[7:0])})
		else $error("banked address wrong");
	a_index_addr: assert property (@(posedge pclk) disable iff (!presetn)
		start && !pwdata[8] && xinst_r && pwdata[7:0] <= `BAI_IDX_LIMIT |=>
		faddr_r == 12'($past(base_s2_r) + {4'h0, $past(pwdata[7:0])}))
		else $error("indexed address wrong");
	a_zero_flag: assert property (@(posedge pclk) disable iff (!presetn)
		busy_r && phase_r == BAI_Q4 |=> flags_r.z == (8'($past(acc_r) + $past(opnd_r)) == 8'h00) &&
		flags_r.c == (9'({1'b0, $past(acc_r)} + {1'b0, $past(opnd_r)}) > 9'h0ff))
		else $error("flags not from sum");
	a_four_phase: assert property (@(posedge pclk) disable iff (!presetn)
		start && dec_nxt.is_file |=> busy_r [*4] ##1 !busy_r)
		else $error("instruction cycle not four phases");
	a_pready_gap: assert property (@(posedge pclk) disable iff (!presetn)
		psel && penable && !pready |=> pready ##1 !pready)
		else $error("apb answer timing wrong");
endmodule
`default_nettype wire

// file: inc/bai_map.svh
// Register offsets, field positions, reset values and timing counts for the add executor
`ifndef BAI_MAP_SVH
`define BAI_MAP_SVH
`define BAI_OFF_CTRL 12'h000
`define BAI_OFF_INSTR 12'h004
`define BAI_OFF_ACC 12'h008
`define BAI_OFF_BANK 12'h00c
`define BAI_OFF_STATUS 12'h010
`define BAI_OFF_FADDR 12'h014
`define BAI_OFF_FDATA 12'h018
`define BAI_CTRL_XINST 0
`define BAI_ST_C 0
`define BAI_ST_DC 1
`define BAI_ST_Z 2
`define BAI_ST_OV 3
`define BAI_ST_N 4
`define BAI_ST_BUSY 8
`define BAI_ST_ILLEGAL 9
`define BAI_ACC_RST 8'h00
`define BAI_BANK_RST 4'h0
`define BAI_IDX_LIMIT 8'h5f
`define BAI_ACCESS_SPLIT 8'h60
`define BAI_ACCESS_SFR_BANK 4'hf
`define BAI_OP_LIT 8'h0f
`define BAI_OP_FILE 6'h09
`define BAI_PHASES 2'd3
`endif

// file: inc/bai_pkg.sv
// Types shared by the add executor
`default_nettype none
package bai_pkg;
	typedef enum logic [1:0] {
		BAI_Q1,
		BAI_Q2,
		BAI_Q3,
		BAI_Q4
	} bai_phase_t;
	typedef struct packed {
		logic is_lit;
		logic is_file;
		logic dest_file;
		logic bank_sel;
		logic [7:0] operand;
	} bai_dec_t;
	typedef struct packed {
		logic n;
		logic ov;
		logic z;
		logic dc;
		logic c;
	} bai_flags_t;
endpackage
`default_nettype wire

// file: dv/bai_apb_bfm.sv
// APB master model for the add executor's register port
`default_nettype none
module bai_apb_bfm (
	// Clock
	input wire logic pclk,
	// Request
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [11:0] paddr,
	output logic [31:0] pwdata,
	// Answer
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
	end
	// One transfer, held until pready is seen high at an edge
	task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
			output logic [31:0] r, output logic e);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
endmodule
`default_nettype wire

// file: dv/tb.sv
// Self-checking testbench for the add executor
`include "bai_map.svh"
`default_nettype none
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	// ----------
	// Harness
	// ----------
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel, penable, pwrite, pready, pslverr, er;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [11:0] index_base = 12'h100;
	int err_count = 0;
	int checks = 0;
	always #20 pclk = ~pclk;
	bai_apb_bfm i_bfm (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
	bai_core i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.index_base(index_base));
	// ----------
	// Helpers
	// ----------
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		checks++;
		if (s !== e) begin
			err_count++;
			$display("wrong value at %0t: seen %h expected %h", $time, s, e);
		end
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		i_bfm.xfer(1'b1, a, d, rd, er);
	endtask
	task automatic rdc(input logic [11:0] a, input logic [31:0] e);
		i_bfm.xfer(1'b0, a, 32'h0, rd, er);
		chk(rd, e);
	endtask
	task automatic st(input logic [9:0] e);
		i_bfm.xfer(1'b0, `BAI_OFF_STATUS, 32'h0, rd, er);
		chk({22'h0, rd[9:0]}, {22'h0, e});
	endtask
	task automatic mem(input logic [11:0] a, input logic [7:0] d);
		wr(`BAI_OFF_FADDR, {20'h0, a});
		wr(`BAI_OFF_FDATA, {24'h0, d});
	endtask
	task automatic mchk(input logic [11:0] a, input logic [7:0] e);
		wr(`BAI_OFF_FADDR, {20'h0, a});
		rdc(`BAI_OFF_FDATA, {24'h0, e});
	endtask
	task automatic op(input logic [7:0] a, input logic [15:0] i);
		wr(`BAI_OFF_ACC, {24'h0, a});
		wr(`BAI_OFF_INSTR, {16'h0, i});
		i_bfm.xfer(1'b0, `BAI_OFF_STATUS, 32'h0, rd, er);
		chk({31'h0, rd[8]}, 32'h1);
	endtask
	// ----------
	// Scenarios
	// ----------
	task automatic t_lit;
		op(8'h10, 16'h0f15);
		rdc(`BAI_OFF_ACC, 32'h25);
		st(10'h000);
		op(8'hff, 16'h0f01);
		rdc(`BAI_OFF_ACC, 32'h00);
		st(10'h007);
		op(8'h7f, 16'h0f01);
		st(10'h01a);
	endtask
	task automatic t_file;
		wr(`BAI_OFF_BANK, 32'h2);
		mem(12'h2c2, 8'hc2);
		op(8'h17, 16'h25c2);
		rdc(`BAI_OFF_ACC, 32'hd9);
		mchk(12'h2c2, 8'hc2);
		st(10'h010);
		mem(12'hf70, 8'h7f);
		op(8'h01, 16'h2670);
		mchk(12'hf70, 8'h80);
		rdc(`BAI_OFF_ACC, 32'h01);
		st(10'h01a);
		mem(12'h05f, 8'h05);
		op(8'h03, 16'h265f);
		mchk(12'h05f, 8'h08);
	endtask
	task automatic t_idx;
		wr(`BAI_OFF_CTRL, 32'h1);
		mem(12'h15f, 8'h02);
		op(8'h01, 16'h265f);
		mchk(12'h15f, 8'h03);
		mem(12'hf60, 8'h10);
		op(8'h01, 16'h2660);
		mchk(12'hf60, 8'h11);
		index_base <= 12'h200;
		mem(12'h210, 8'h20);
		op(8'h01, 16'h2610);
		mchk(12'h210, 8'h21);
	endtask
	task automatic t_bad;
		wr(`BAI_OFF_ACC, 32'h33);
		wr(`BAI_OFF_INSTR, 32'h0f01);
		wr(`BAI_OFF_INSTR, 32'h0f01);
		chk({31'h0, er}, 32'h1);
		rdc(`BAI_OFF_ACC, 32'h34);
		wr(`BAI_OFF_INSTR, 32'h0b00);
		rdc(`BAI_OFF_ACC, 32'h34);
		st(10'h200);
		i_bfm.xfer(1'b0, 12'h0fc, 32'h0, rd, er);
		chk({31'h0, er}, 32'h1);
	endtask
	task automatic results;
		$display("checks %0d errors %0d", checks, err_count);
		if (err_count == 0 && checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	initial begin
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		rdc(`BAI_OFF_ACC, 32'h0);
		st(10'h000);
		t_lit;
		t_file;
		t_idx;
		t_bad;
		results;
	end
	initial begin
		#100us;
		err_count++;
		results;
	end
endmodule
`default_nettype wire
